// >>> rtl/rrb_pkg.sv
// Shared constants and types for the regulator register bank
package rrb_pkg;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam int            NREG          = 39;
  localparam logic [7:0]    A_DEVICE_REVISION_ID     = 8'h00;
  localparam logic [7:0]    A_OTP_VER     = 8'h01;
  localparam logic [7:0]    A_BUCK0_CA    = 8'h02;
  localparam logic [7:0]    A_BUCK0_CB    = 8'h03;
  localparam logic [7:0]    A_BUCK1_CA    = 8'h04;
  localparam logic [7:0]    A_BUCK1_CB    = 8'h05;
  localparam logic [7:0]    A_CONV0_VOLTAGE_CODE  = 8'h06;
  localparam logic [7:0]    A_CONV1_VOLTAGE_CODE  = 8'h07;
  localparam logic [7:0]    A_LDO0_CONTROL   = 8'h08;
  localparam logic [7:0]    A_LDO1_CONTROL   = 8'h09;
  localparam logic [7:0]    A_PG_CFG_A    = 8'h15;
  localparam logic [7:0]    A_PG_CFG_B    = 8'h16;
  localparam logic [7:0]    A_POWER_GOOD_FAULT_FLAGS    = 8'h17;
  localparam logic [7:0]    A_SOFT_RST    = 8'h18;
  localparam logic [7:0]    A_IRQ_TOP_A   = 8'h19;
  localparam logic [7:0]    A_IRQ_TOP_B   = 8'h1a;
  localparam logic [7:0]    A_IRQ_CONV    = 8'h1b;
  localparam logic [7:0]    A_IRQ_LIN     = 8'h1c;
  localparam logic [7:0]    A_STAT_TOP    = 8'h1d;
  localparam logic [7:0]    A_STAT_CONV   = 8'h1e;
  localparam logic [7:0]    A_STAT_LIN    = 8'h1f;
  localparam logic [7:0]    A_MASK_TOP_A  = 8'h20;
  localparam logic [7:0]    A_MASK_TOP_B  = 8'h21;
  localparam logic [7:0]    A_MASK_CONV   = 8'h22;
  localparam logic [7:0]    A_MASK_LIN    = 8'h23;
  localparam logic [7:0]    A_LOAD_SEL    = 8'h24;
  localparam logic [7:0]    A_LOAD_HI     = 8'h25;
  localparam logic [7:0]    A_LOAD_LO     = 8'h26;

  // ---------------------------------------------------------------
  // Writable and readable bit masks
  // ---------------------------------------------------------------
  localparam logic [7:0]    M_BUCK0_CA    = 8'h1f;
  localparam logic [7:0]    M_BUCK1_CA    = 8'h0f;
  localparam logic [7:0]    M_BUCK_CB     = 8'h3f;
  localparam logic [7:0]    M_FULL        = 8'hff;
  localparam logic [7:0]    M_LDO_CTRL    = 8'h07;
  localparam logic [7:0]    M_PG_CFG_A    = 8'hdf;
  localparam logic [7:0]    M_PG_CFG_B    = 8'h07;
  localparam logic [7:0]    M_POWER_GOOD_FAULT_FLAGS    = 8'h0f;
  localparam logic [7:0]    M_BIT0        = 8'h01;
  localparam logic [7:0]    M_IRQ_SUB     = 8'h77;
  localparam logic [7:0]    M_STAT_TOP    = 8'h9e;
  localparam logic [7:0]    M_STAT_SUB    = 8'hdd;
  localparam logic [7:0]    M_MASK_TOP_A  = 8'h95;
  localparam logic [7:0]    M_NONE        = 8'h00;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int            B_ON          = 0;
  localparam int            B_PIN_GATE    = 1;
  localparam int            B_DISCHARGE   = 2;
  localparam int            B_FIXED_FREQ  = 3;
  localparam int            B_MULTIPHASE  = 4;
  localparam int            B_ILIM_LO     = 3;
  localparam int            B_RAMP_LO     = 0;
  localparam int            W_CODE3       = 3;
  localparam int            W_LOAD        = 9;
  localparam logic [7:0]    RST_DISCHARGE = 8'h04;

  // ---------------------------------------------------------------
  // Serial link constants
  // ---------------------------------------------------------------
  localparam logic [3:0]    BITS_BYTE     = 4'h8;
  localparam logic [6:0]    DEV_ADDR_DEF  = 7'h60;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    PH_IDLE    = 4'b0000,
    PH_DEVADDR = 4'b0001,
    PH_ADR_ACK = 4'b0010,
    PH_REGIDX  = 4'b0011,
    PH_IDX_ACK = 4'b0100,
    PH_WRDATA  = 4'b0101,
    PH_WR_ACK  = 4'b0110,
    PH_RDDATA  = 4'b0111,
    PH_RD_ACK  = 4'b1000
  } rrb_phase_e;

  typedef struct packed {
    logic [7:0]        top_evt;
    logic [7:0]        conv_evt;
    logic [7:0]        lin_evt;
    logic [7:0]        top_stat;
    logic [7:0]        conv_stat;
    logic [7:0]        lin_stat;
    logic [3:0]        power_good_fault_flags;
    logic [W_LOAD-1:0] load_cur;
  } rrb_status_s;

  typedef struct packed {
    logic [3:0]         reg_on;
    logic [3:0]         discharge_on;
    logic               conv0_force_fixed_freq;
    logic               conv1_force_fixed_freq;
    logic               conv0_force_multiphase;
    logic [W_CODE3-1:0] conv0_current_limit;
    logic [W_CODE3-1:0] conv1_current_limit;
    logic [W_CODE3-1:0] conv0_ramp_rate;
    logic [W_CODE3-1:0] conv1_ramp_rate;
    logic [7:0]         conv0_voltage_code;
    logic [7:0]         conv1_voltage_code;
  } rrb_ctrl_s;

  typedef logic [NREG-1:0][7:0] rrb_regs_t;

  // Power-on image: discharge paths connected, all else cleared
  function automatic rrb_regs_t rrb_reset_image();
    rrb_regs_t r;
    r = '0;
    r[A_BUCK0_CA] = RST_DISCHARGE;
    r[A_BUCK1_CA] = RST_DISCHARGE;
    r[A_LDO0_CONTROL] = RST_DISCHARGE;
    r[A_LDO1_CONTROL] = RST_DISCHARGE;
    return r;
  endfunction

  localparam rrb_regs_t     REG_RESET     = rrb_reset_image();

endpackage

// >>> rtl/rrb_top.sv
// Serial-access control and status register bank of the regulator manager
`timescale 1ns/1ps

module rrb_top
#(
  parameter logic [6:0] DEV_ADDR     = rrb_pkg::DEV_ADDR_DEF,
  // Arbitrary identification values
  parameter logic [7:0] DEVICE_REVISION_ID_CODE = 8'h40,
  parameter logic [7:0] OTP_VER_CODE = 8'h01
)
(
  // Clock and reset
  input  wire logic                 SYS_CLK_I,
  input  wire logic                 RST_B_I,
  // Serial bus
  input  wire logic                 SCL_I,
  input  wire logic                 SDA_I,
  output logic                      SDA_O,
  output logic                      SDA_OE_O,
  // Enable pin and analog status
  input  wire logic                 EN_PIN_I,
  input  wire rrb_pkg::rrb_status_s STATUS_I,
  // Regulator controls
  output rrb_pkg::rrb_ctrl_s        CTRL_O
);
  import rrb_pkg::*;

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    rrb_phase_e  phase;
    logic [1:0]  scl_s;
    logic [1:0]  sda_s;
    logic        scl_p;
    logic        sda_p;
    logic [1:0]  en_s;
    rrb_status_s st_m;
    rrb_status_s st_s;
    logic [3:0]  cnt;
    logic [7:0]  sh;
    logic        rw;
    logic        nack;
    logic [7:0]  idx;
    rrb_regs_t   regs;
    logic        sda_oe;
    logic        sda_o;
    rrb_ctrl_s   ctrl;
  } rrb_state_s;

  rrb_state_s s_q;
  rrb_state_s s_d;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  // Bits that a host write may change; zero marks read-only or unmapped
  function automatic logic [7:0] wmask(input logic [7:0] a);
    case (a)
      A_BUCK0_CA:                  wmask = M_BUCK0_CA;
      A_BUCK1_CA:                  wmask = M_BUCK1_CA;
      A_BUCK0_CB, A_BUCK1_CB:      wmask = M_BUCK_CB;
      A_CONV0_VOLTAGE_CODE, A_CONV1_VOLTAGE_CODE:  wmask = M_FULL;
      A_LDO0_CONTROL, A_LDO1_CONTROL:    wmask = M_LDO_CTRL;
      A_PG_CFG_A:                  wmask = M_PG_CFG_A;
      A_PG_CFG_B:                  wmask = M_PG_CFG_B;
      A_SOFT_RST:                  wmask = M_BIT0;
      A_IRQ_TOP_A:                 wmask = M_FULL;
      A_IRQ_CONV, A_IRQ_LIN:       wmask = M_IRQ_SUB;
      A_MASK_TOP_A:                wmask = M_MASK_TOP_A;
      A_MASK_TOP_B:                wmask = M_BIT0;
      A_MASK_CONV, A_MASK_LIN:     wmask = M_STAT_SUB;
      A_LOAD_SEL:                  wmask = M_BIT0;
      default:                     wmask = M_NONE;
    endcase
  endfunction

  function automatic logic [7:0] rd_byte(input logic [7:0] a, input rrb_regs_t r,
                                         input rrb_status_s st);
    case (a)
      A_DEVICE_REVISION_ID:   rd_byte = DEVICE_REVISION_ID_CODE;
      A_OTP_VER:   rd_byte = OTP_VER_CODE;
      A_POWER_GOOD_FAULT_FLAGS:  rd_byte = {4'h0, st.power_good_fault_flags} & M_POWER_GOOD_FAULT_FLAGS;
      A_STAT_TOP:  rd_byte = st.top_stat & M_STAT_TOP;
      A_STAT_CONV: rd_byte = st.conv_stat & M_STAT_SUB;
      A_STAT_LIN:  rd_byte = st.lin_stat & M_STAT_SUB;
      A_LOAD_HI:   rd_byte = {7'h00, st.load_cur[W_LOAD-1]};
      A_LOAD_LO:   rd_byte = st.load_cur[7:0];
      default:     rd_byte = (a < 8'(NREG)) ? (r[a[5:0]] & wmask(a)) : 8'h00;
    endcase
  endfunction

  // Effective on state of one regulator
  function automatic logic eff_on(input logic [7:0] c, input logic pin);
    eff_on = c[B_ON] & (~c[B_PIN_GATE] | pin);
  endfunction

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  logic       scl_rise;
  logic       scl_fall;
  logic       start_c;
  logic       stop_c;
  logic [7:0] wr_data;
  logic [7:0] rd_data;
  logic [7:0] evt_now;

  always_comb
  begin
    s_d = s_q;
    wr_data = 8'h00;
    // Synchronisers; only the second stage feeds any logic
    s_d.scl_s = {s_q.scl_s[0], SCL_I};
    s_d.sda_s = {s_q.sda_s[0], SDA_I};
    s_d.en_s  = {s_q.en_s[0], EN_PIN_I};
    s_d.st_m  = STATUS_I;
    s_d.st_s  = s_q.st_m;
    s_d.scl_p = s_q.scl_s[1];
    s_d.sda_p = s_q.sda_s[1];
    scl_rise = s_q.scl_s[1] & ~s_q.scl_p;
    scl_fall = ~s_q.scl_s[1] & s_q.scl_p;
    start_c  = s_q.scl_s[1] & s_q.scl_p & s_q.sda_p & ~s_q.sda_s[1];
    stop_c   = s_q.scl_s[1] & s_q.scl_p & ~s_q.sda_p & s_q.sda_s[1];
    rd_data  = rd_byte(s_q.idx, s_q.regs, s_q.st_s);
    // Events aimed at the flag byte under the index, kept through a clear
    evt_now  = (s_q.idx == A_IRQ_TOP_A) ? s_q.st_s.top_evt
             : (s_q.idx == A_IRQ_CONV)  ? (s_q.st_s.conv_evt & M_IRQ_SUB)
             : (s_q.idx == A_IRQ_LIN)   ? (s_q.st_s.lin_evt & M_IRQ_SUB)
             : 8'h00;

    // Sticky event flags; a new event wins over a clear in the same cycle
    s_d.regs[A_IRQ_TOP_A] = s_q.regs[A_IRQ_TOP_A] | s_q.st_s.top_evt;
    s_d.regs[A_IRQ_CONV]  = s_q.regs[A_IRQ_CONV] | (s_q.st_s.conv_evt & M_IRQ_SUB);
    s_d.regs[A_IRQ_LIN]   = s_q.regs[A_IRQ_LIN] | (s_q.st_s.lin_evt & M_IRQ_SUB);
    // Soft reset bit is self-clearing
    s_d.regs[A_SOFT_RST]  = 8'h00;

    if (start_c)
    begin
      s_d.phase  = PH_DEVADDR;
      s_d.cnt    = 4'h0;
      s_d.sda_oe = 1'b0;
    end
    else if (stop_c)
    begin
      s_d.phase  = PH_IDLE;
      s_d.sda_oe = 1'b0;
    end
    else if (scl_rise)
    begin
      case (s_q.phase)
        PH_DEVADDR, PH_REGIDX, PH_WRDATA:
        begin
          s_d.sh  = {s_q.sh[6:0], s_q.sda_s[1]};
          s_d.cnt = s_q.cnt + 4'h1;
        end
        PH_RDDATA: s_d.cnt = s_q.cnt + 4'h1;
        PH_RD_ACK: s_d.nack = s_q.sda_s[1];
        default:   s_d.cnt = s_q.cnt;
      endcase
    end
    else if (scl_fall)
    begin
      case (s_q.phase)
        PH_DEVADDR:
        begin
          if (s_q.cnt == BITS_BYTE)
          begin
            if (s_q.sh[7:1] == DEV_ADDR)
            begin
              s_d.rw     = s_q.sh[0];
              s_d.sda_oe = 1'b1;
              s_d.phase  = PH_ADR_ACK;
            end
            else
            begin
              s_d.phase = PH_IDLE;
            end
          end
        end
        PH_REGIDX:
        begin
          if (s_q.cnt == BITS_BYTE)
          begin
            s_d.idx    = s_q.sh;
            s_d.sda_oe = 1'b1;
            s_d.phase  = PH_IDX_ACK;
          end
        end
        PH_WRDATA:
        begin
          if (s_q.cnt == BITS_BYTE)
          begin
            wr_data = s_q.sh;
            if (s_q.idx < 8'(NREG))
            begin
              case (s_q.idx)
                A_IRQ_TOP_A, A_IRQ_CONV, A_IRQ_LIN:
                  // Write one to clear, new events still land
                  s_d.regs[s_q.idx[5:0]] = (s_q.regs[s_q.idx[5:0]] & ~wr_data) | evt_now;
                A_SOFT_RST:
                  if (wr_data[0])
                  begin
                    s_d.regs = REG_RESET;
                  end
                default:
                  s_d.regs[s_q.idx[5:0]] = (s_q.regs[s_q.idx[5:0]] & ~wmask(s_q.idx))
                                         | (wr_data & wmask(s_q.idx));
              endcase
            end
            s_d.idx    = s_q.idx + 8'h01;
            s_d.sda_oe = 1'b1;
            s_d.phase  = PH_WR_ACK;
          end
        end
        PH_ADR_ACK:
        begin
          s_d.cnt = 4'h0;
          if (s_q.rw)
          begin
            // Read uses the index left by the preceding write phase
            s_d.sh     = rd_data;
            s_d.sda_oe = ~rd_data[7];
            s_d.phase  = PH_RDDATA;
          end
          else
          begin
            s_d.sda_oe = 1'b0;
            s_d.phase  = PH_REGIDX;
          end
        end
        PH_IDX_ACK, PH_WR_ACK:
        begin
          s_d.cnt    = 4'h0;
          s_d.sda_oe = 1'b0;
          s_d.phase  = PH_WRDATA;
        end
        PH_RDDATA:
        begin
          if (s_q.cnt == BITS_BYTE)
          begin
            s_d.sda_oe = 1'b0;
            s_d.phase  = PH_RD_ACK;
          end
          else
          begin
            s_d.sh     = {s_q.sh[6:0], 1'b0};
            s_d.sda_oe = ~s_q.sh[6];
          end
        end
        PH_RD_ACK:
        begin
          s_d.cnt = 4'h0;
          if (s_q.nack)
          begin
            s_d.phase = PH_IDLE;
          end
          else
          begin
            // No increment on reads: the same register is sent again
            s_d.sh     = rd_data;
            s_d.sda_oe = ~rd_data[7];
            s_d.phase  = PH_RDDATA;
          end
        end
        default: s_d.phase = PH_IDLE;
      endcase
    end

    // Regulator control outputs, registered one cycle after the bank
    s_d.ctrl.reg_on[0] = eff_on(s_q.regs[A_BUCK0_CA], s_q.en_s[1]);
    s_d.ctrl.reg_on[1] = eff_on(s_q.regs[A_BUCK1_CA], s_q.en_s[1]);
    s_d.ctrl.reg_on[2] = eff_on(s_q.regs[A_LDO0_CONTROL], s_q.en_s[1]);
    s_d.ctrl.reg_on[3] = eff_on(s_q.regs[A_LDO1_CONTROL], s_q.en_s[1]);
    s_d.ctrl.discharge_on[0] = s_q.regs[A_BUCK0_CA][B_DISCHARGE]
                             & ~eff_on(s_q.regs[A_BUCK0_CA], s_q.en_s[1]);
    s_d.ctrl.discharge_on[1] = s_q.regs[A_BUCK1_CA][B_DISCHARGE]
                             & ~eff_on(s_q.regs[A_BUCK1_CA], s_q.en_s[1]);
    s_d.ctrl.discharge_on[2] = s_q.regs[A_LDO0_CONTROL][B_DISCHARGE]
                             & ~eff_on(s_q.regs[A_LDO0_CONTROL], s_q.en_s[1]);
    s_d.ctrl.discharge_on[3] = s_q.regs[A_LDO1_CONTROL][B_DISCHARGE]
                             & ~eff_on(s_q.regs[A_LDO1_CONTROL], s_q.en_s[1]);
    s_d.ctrl.conv0_force_fixed_freq = s_q.regs[A_BUCK0_CA][B_FIXED_FREQ];
    s_d.ctrl.conv1_force_fixed_freq = s_q.regs[A_BUCK1_CA][B_FIXED_FREQ];
    s_d.ctrl.conv0_force_multiphase = s_q.regs[A_BUCK0_CA][B_MULTIPHASE];
    // Reserved codes are passed through unchanged; the analog side owns them
    s_d.ctrl.conv0_current_limit = s_q.regs[A_BUCK0_CB][B_ILIM_LO +: W_CODE3];
    s_d.ctrl.conv1_current_limit = s_q.regs[A_BUCK1_CB][B_ILIM_LO +: W_CODE3];
    s_d.ctrl.conv0_ramp_rate = s_q.regs[A_BUCK0_CB][B_RAMP_LO +: W_CODE3];
    s_d.ctrl.conv1_ramp_rate = s_q.regs[A_BUCK1_CB][B_RAMP_LO +: W_CODE3];
    s_d.ctrl.conv0_voltage_code = s_q.regs[A_CONV0_VOLTAGE_CODE];
    s_d.ctrl.conv1_voltage_code = s_q.regs[A_CONV1_VOLTAGE_CODE];
    s_d.sda_o = 1'b0;
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge SYS_CLK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
    begin
      s_q        <= '0;
      s_q.phase  <= PH_IDLE;
      s_q.scl_s  <= 2'h3;
      s_q.sda_s  <= 2'h3;
      s_q.scl_p  <= 1'b1;
      s_q.sda_p  <= 1'b1;
      s_q.regs   <= REG_RESET;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign SDA_O    = s_q.sda_o;
  assign SDA_OE_O = s_q.sda_oe;
  assign CTRL_O   = s_q.ctrl;

endmodule

// >>> tb/rrb_top_asserts.sv
// Port-level checker for the regulator register bank
`timescale 1ns/1ps
module rrb_top_asserts
(
  // Clock and reset
  input wire logic               SYS_CLK_I,
  input wire logic               RST_B_I,
  // Serial bus and pin
  input wire logic               SCL_I,
  input wire logic               SDA_OE_O,
  input wire logic               EN_PIN_I,
  // Regulator controls
  input wire rrb_pkg::rrb_ctrl_s CTRL_O
);
  import rrb_pkg::*;
  // ----------------------------------------
  // Helper history of the enable pin
  // ----------------------------------------
  logic [5:0] en_hist_q;
  logic       en_mix;
  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (!RST_B_I);
  always_ff @(posedge SYS_CLK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
      en_hist_q <= 6'h00;
    else
      en_hist_q <= {en_hist_q[4:0], EN_PIN_I};
  end
  // Six deep, covers the two-flop synchroniser plus output register
  assign en_mix = (en_hist_q != 6'h00) && (en_hist_q != 6'h3f);
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  disch_excl_a: assert property ((CTRL_O.discharge_on & CTRL_O.reg_on) == 4'h0)
    else $error("discharge path on while regulator on");
  reset_img_a: assert property (
    $rose(RST_B_I) |-> CTRL_O.reg_on == 4'h0 ##[0:2] CTRL_O.discharge_on == 4'hf)
    else $error("control outputs differ from power-on image");
  on_cause_a: assert property (
    !$stable(CTRL_O.reg_on) |-> ##[0:2] (SDA_OE_O || en_mix))
    else $error("enable changed without write or pin change");
  mode_ack_a: assert property (
    !$stable({CTRL_O.conv0_force_fixed_freq, CTRL_O.conv1_force_fixed_freq,
              CTRL_O.conv0_force_multiphase}) |-> ##[0:2] SDA_OE_O)
    else $error("mode bits changed outside a write");
  limit_ack_a: assert property (
    !$stable({CTRL_O.conv0_current_limit, CTRL_O.conv1_current_limit,
              CTRL_O.conv0_ramp_rate, CTRL_O.conv1_ramp_rate}) |-> ##[0:2] SDA_OE_O)
    else $error("limit or ramp code changed outside a write");
  vcode_ack_a: assert property (
    !$stable({CTRL_O.conv0_voltage_code, CTRL_O.conv1_voltage_code}) |-> ##[0:2] SDA_OE_O)
    else $error("voltage code changed outside a write");
  oe_scl_low_a: assert property (!$stable(SDA_OE_O) |-> !SCL_I)
    else $error("data line drive changed while clock high");
  ack_delay_a: assert property (
    $rose(SDA_OE_O) |-> !SCL_I && ($past(SCL_I, 4) || $past(SCL_I, 5) || $past(SCL_I, 6)))
    else $error("data line drive not tied to a clock fall");
  cover property ($rose(SDA_OE_O));
  cover property (!$stable(CTRL_O.conv0_voltage_code));
  cover property ($rose(|CTRL_O.reg_on));
endmodule

bind rrb_top rrb_top_asserts i_rrb_top_asserts (
  .SYS_CLK_I(SYS_CLK_I),
  .RST_B_I  (RST_B_I),
  .SCL_I    (SCL_I),
  .SDA_OE_O (SDA_OE_O),
  .EN_PIN_I (EN_PIN_I),
  .CTRL_O   (CTRL_O)
);

// >>> tb/rrb_host.sv
// Serial bus host model for the register bank
`timescale 1ns/1ps
module rrb_host
#(
  parameter logic [6:0] DEV = 7'h60
)
(
  // Clock
  input  wire logic  clk_i,
  // Serial bus
  input  wire logic  sda_i,
  output logic       scl_o,
  output logic       sda_oe_o,
  // Read results
  output logic       rd_stb_o,
  output logic [7:0] rd_dat_o
);
  // ----------------------------------------
  // Bus phases, 8 clocks low and 8 high
  // ----------------------------------------
  initial
  begin
    scl_o    = 1'b1;
    sda_oe_o = 1'b0;
    rd_stb_o = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // Data moves only while clock low
  task automatic bitx(input logic b, output logic s);
    sda_oe_o <= ~b;
    tick(4);
    scl_o <= 1'b1;
    tick(8);
    s = sda_i;
    scl_o <= 1'b0;
    tick(4);
  endtask
  task automatic start();
    sda_oe_o <= 1'b0;
    tick(4);
    scl_o <= 1'b1;
    tick(8);
    sda_oe_o <= 1'b1;
    tick(8);
    scl_o <= 1'b0;
    tick(4);
  endtask
  task automatic stop();
    sda_oe_o <= 1'b1;
    tick(4);
    scl_o <= 1'b1;
    tick(8);
    sda_oe_o <= 1'b0;
    tick(8);
  endtask
  task automatic wb(input logic [7:0] d, output logic ok);
    logic s;
    for (int i = 7; i >= 0; i--)
      bitx(d[i], s);
    bitx(1'b1, s);
    ok = ~s;
  endtask
  task automatic rb(input logic last, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--)
      bitx(1'b1, d[i]);
    rd_dat_o <= d;
    rd_stb_o <= 1'b1;
    tick(1);
    rd_stb_o <= 1'b0;
    bitx(last, s);
  endtask
  // One transfer, index steps after each data byte
  task automatic wr(input logic [7:0] a, input logic [7:0] d[$], output logic ok);
    logic k;
    start();
    wb({DEV, 1'b0}, ok);
    wb(a, k);
    ok &= k;
    foreach (d[i])
    begin
      wb(d[i], k);
      ok &= k;
    end
    stop();
  endtask
  // Index sent first, then the same register read n times
  task automatic rd(input logic [7:0] a, input int n, output logic ok);
    logic       k;
    logic [7:0] x;
    start();
    wb({DEV, 1'b0}, ok);
    wb(a, k);
    ok &= k;
    start();
    wb({DEV, 1'b1}, k);
    ok &= k;
    for (int i = 0; i < n; i++)
      rb(i == n - 1, x);
    stop();
  endtask
endmodule

// >>> tb/rrb_top_tb.sv
// Self-checking bench for the regulator register bank
`timescale 1ns/1ps
module rrb_top_tb;
  import rrb_pkg::*;
  // ----------------------------------------
  // Signals and instances
  // ----------------------------------------
  localparam logic [7:0] ID_A = 8'h9c; // Arbitrary value
  localparam logic [7:0] ID_B = 8'h3c; // Arbitrary value
  logic        clk;
  logic        rst_b;
  logic        en_pin;
  logic        scl;
  logic        h_oe;
  logic        sda_oe;
  logic        sda_o;
  logic        rd_stb;
  logic [7:0]  rd_dat;
  logic [7:0]  w [2:9];
  logic [7:0]  msk [2:9];
  logic [7:0]  expq [$];
  logic [15:0] lfsr;
  rrb_status_s st;
  rrb_ctrl_s   ctrl;
  int          n_fail;
  int          checks_done;
  // Pull-up wire, low when any party drives
  wire         sda = ~(h_oe | sda_oe);
  rrb_top #(.DEV_ADDR(DEV_ADDR_DEF), .DEVICE_REVISION_ID_CODE(ID_A), .OTP_VER_CODE(ID_B)) i_rrb_top (
    .SYS_CLK_I(clk), .RST_B_I(rst_b), .SCL_I(scl), .SDA_I(sda), .SDA_O(sda_o),
    .SDA_OE_O(sda_oe), .EN_PIN_I(en_pin), .STATUS_I(st), .CTRL_O(ctrl));
  rrb_host #(.DEV(DEV_ADDR_DEF)) i_rrb_host (
    .clk_i(clk), .sda_i(sda), .scl_o(scl), .sda_oe_o(h_oe), .rd_stb_o(rd_stb), .rd_dat_o(rd_dat));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [7:0] rnd();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr[7:0];
  endfunction
  function automatic rrb_ctrl_s exp_ctrl(input logic en);
    rrb_ctrl_s  e;
    logic [7:0] c [4];
    c = '{w[2], w[4], w[8], w[9]};
    e = '0;
    for (int i = 0; i < 4; i++)
    begin
      e.reg_on[i] = c[i][0] & (~c[i][1] | en);
      e.discharge_on[i] = c[i][2] & ~e.reg_on[i];
    end
    e.conv0_force_fixed_freq = w[2][3];
    e.conv1_force_fixed_freq = w[4][3];
    e.conv0_force_multiphase = w[2][4];
    e.conv0_current_limit = w[3][5:3];
    e.conv1_current_limit = w[5][5:3];
    e.conv0_ramp_rate = w[3][2:0];
    e.conv1_ramp_rate = w[5][2:0];
    e.conv0_voltage_code = w[6];
    e.conv1_voltage_code = w[7];
    return e;
  endfunction
  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    checks_done++;
    if (g !== e)
    begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rdx(input logic [7:0] a, input logic [7:0] e, input int n);
    logic ok;
    repeat (n) expq.push_back(e);
    i_rrb_host.rd(a, n, ok);
    chk("ack", 64'h1, 64'(ok));
  endtask
  task automatic rd_all();
    for (int a = 2; a < 10; a++)
      rdx(8'(a), w[a], 1);
  endtask
  task automatic w_rst();
    w = '{8'h04, 8'h00, 8'h04, 8'h00, 8'h00, 8'h00, 8'h04, 8'h04};
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // ----------------------------------------
  // Processes
  // ----------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk)
    if (rd_stb === 1'b1)
      chk("read", 64'(expq.pop_front()), 64'(rd_dat));
  initial
  begin
    repeat (90000) @(posedge clk);
    n_fail++;
    results();
  end
  initial
  begin
    logic [7:0] v;
    logic       ok;
    logic [7:0] d [$];
    rst_b = 1'b0;
    en_pin = 1'b0;
    st = '0;
    lfsr = 16'h20aa;
    n_fail = 0;
    checks_done = 0;
    msk = '{M_BUCK0_CA, M_BUCK_CB, M_BUCK1_CA, M_BUCK_CB, M_FULL, M_FULL, M_LDO_CTRL, M_LDO_CTRL};
    w_rst();
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    repeat (6) @(posedge clk);
    chk("ctrl", 64'(exp_ctrl(1'b0)), 64'(ctrl));
    rdx(A_DEVICE_REVISION_ID, ID_A, 1);
    rdx(A_OTP_VER, ID_B, 1);
    rd_all();
    $display("test reset_image done");
    // Burst starts on read-only bytes and ends on unmapped byte 0x0a
    for (int r = 0; r < 3; r++)
    begin
      d = '{8'hff, 8'hff};
      for (int a = 2; a < 11; a++)
      begin
        v = rnd();
        d.push_back(v);
        if (a < 10)
          w[a] = v & msk[a];
      end
      i_rrb_host.wr(A_DEVICE_REVISION_ID, d, ok);
      chk("ack", 64'h1, 64'(ok));
      for (int k = 0; k < 2; k++)
      begin
        en_pin <= ~en_pin;
        repeat (8) @(posedge clk);
        chk("ctrl", 64'(exp_ctrl(en_pin)), 64'(ctrl));
      end
      rd_all();
      rdx(A_DEVICE_REVISION_ID, ID_A, 2);
      rdx(8'h0a, 8'h00, 1);
      $display("test write_read round %0d done", r);
    end
    d = '{8'h01};
    i_rrb_host.wr(A_SOFT_RST, d, ok);
    w_rst();
    repeat (4) @(posedge clk);
    chk("ctrl", 64'(exp_ctrl(en_pin)), 64'(ctrl));
    rdx(A_SOFT_RST, 8'h00, 1);
    $display("test soft_reset done");
    i_rrb_host.wr(A_BUCK0_CA, d, ok);
    rst_b <= 1'b0;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    repeat (6) @(posedge clk);
    chk("ctrl", 64'(exp_ctrl(en_pin)), 64'(ctrl));
    $display("test second_reset done");
    results();
  end
endmodule
